// [core/lbc_regs.svh]
// constant definitions for the lookaside cache bus control
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH
`define LBC_AW 32
`define LBC_DW 64
`define LBC_TT_READ 1
`define LBC_TT_DATA 3
`define LBC_TT_CLEAN 5'h00
`define LBC_TT_RD_LOW 4'ha
`define LBC_LINE_LSB 5
`define LBC_BEAT_LSB 3
`define LBC_LAST_BURST 2'h3
`define LBC_LAST_SINGLE 2'h0
`define LBC_FIFO_DEPTH 8
`define LBC_FILL_MAX_LEVEL 4'h4
`endif

// [core/lbc_pkg.sv]
// shared types for the lookaside cache bus control
`include "lbc_regs.svh"
package lbc_pkg;
   typedef struct packed {
      logic [`LBC_AW-1:0] addr;
      logic [0:4] tt;
      logic burst;
      logic inhibit;
      logic wthru;
   } lbc_req_t;
   typedef enum logic [4:0] {
      DK_OTHER = 5'h01, DK_HIT_RD = 5'h02, DK_HIT_WR = 5'h04, DK_FILL = 5'h08, DK_UPD = 5'h10
   } lbc_kind_t;
   typedef struct packed {
      lbc_kind_t kind;
      logic burst;
      logic [`LBC_AW-1:0] addr;
   } lbc_ten_t;
   typedef enum logic [2:0] {
      TO_NONE = 3'h0, TO_INVAL = 3'h1, TO_FILL = 3'h2, TO_DIRTY = 3'h3, TO_CLEAN = 3'h4
   } lbc_tag_op_t;
   typedef struct packed {
      lbc_tag_op_t op;
      logic [`LBC_AW-1:0] addr;
   } lbc_tag_upd_t;
   typedef struct packed {
      logic [`LBC_AW-1:0] addr;
      logic [`LBC_DW-1:0] data;
   } lbc_wr_t;
   typedef enum logic [2:0] {WB_IDLE = 3'h1, WB_HOLD = 3'h2, WB_RUN = 3'h4} lbc_wb_st_t;
endpackage : lbc_pkg

// [core/lbc_fifo.sv]
// write-data fifo between the bus capture and the data array
`timescale 1ns/1ps
module lbc_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(D):0] level
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_q;
   logic out_v_q;
   logic [W-1:0] out_q;
   logic push, load, bypass, from_mem, mem_wr;

   assign in_ready = (cnt_q != (AW+1)'(D));
   assign push = in_valid & in_ready;
   assign load = ~out_v_q | out_ready;
   assign bypass = load & push & (cnt_q == '0);
   assign from_mem = load & (cnt_q != '0);
   assign mem_wr = push & ~bypass;
   assign out_valid = out_v_q;
   assign out_data = out_q;
   assign level = cnt_q;

   always_ff @(posedge clk) begin
      if (clk_en && mem_wr) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (clk_en) begin
         if (mem_wr) wp_q <= AW'(wp_q + 1'b1);
         if (from_mem) rp_q <= AW'(rp_q + 1'b1);
         cnt_q <= (AW+1)'(cnt_q + mem_wr - from_mem);
      end
   end

   // head word always comes out of a register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_v_q <= 1'b0;
         out_q <= '0;
      end else if (clk_en && load) begin
         out_v_q <= from_mem | bypass;
         if (from_mem) out_q <= mem[rp_q];
         else if (bypass) out_q <= in_data;
      end
   end
endmodule : lbc_fifo

// [core/lbc_ctrl.sv]
// lookaside secondary cache bus control: claims, ack pacing, fills, retries
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
`include "lbc_regs.svh"
module lbc_ctrl
   import lbc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic retry_free_fast_mode,
   input wire logic ts,
   input wire lbc_req_t req,
   input wire logic proc_addr_grant,
   input wire logic proc_data_grant,
   input wire logic proc_bus_request,
   input wire logic aack_seen,
   input wire logic artry_seen,
   input wire logic ta_seen,
   input wire logic tea_seen,
   input wire logic [`LBC_DW-1:0] bus_data,
   input wire logic tag_hit,
   input wire logic tag_dirty,
   output logic hit_claim_drive,
   output logic hit_claim_drive_en,
   output logic aack_drive,
   output logic aack_drive_en,
   output logic artry_drive,
   output logic artry_drive_en,
   output logic ta_drive,
   output logic ta_drive_en,
   output logic [`LBC_DW-1:0] data_drive,
   output logic data_drive_en,
   output logic [`LBC_AW-1:0] arr_rd_addr,
   input wire logic [`LBC_DW-1:0] arr_rd_data,
   output logic arr_wr_valid,
   input wire logic arr_wr_ready,
   output lbc_wr_t arr_wr,
   output lbc_tag_upd_t tag_win_upd,
   output lbc_tag_upd_t tag_end_upd,
   output lbc_tag_upd_t tag_wb_upd,
   output logic wb_bus_request,
   output logic [`LBC_AW-1:0] wb_addr,
   input wire logic wb_done
);
   function automatic logic [`LBC_AW-1:0] beat_addr(logic [`LBC_AW-1:0] a, logic [1:0] b);
      logic [1:0] w;
      w = 2'(a[`LBC_LINE_LSB-1:`LBC_BEAT_LSB] + b);
      return {a[`LBC_AW-1:`LBC_LINE_LSB], w, {`LBC_BEAT_LSB{1'b0}}};
   endfunction : beat_addr

   ////////////////////////////////////////////////////////////////////////////
   // address tenure decode
   logic ag_q, ap_q, win_q, brw_q, tail_dat_q, inv_q, aw_q, artry_q;
   logic [`LBC_AW-1:0] tenure_addr_q;
   logic snoop, pr, is_rd, is_dat, snoop_rd, claim_rd, claim_wr, ci_clean, ci_dirty;
   logic wt_hit, sn_hit, retry_now, fill, upd, room, enq, drop;
   logic snl_q, upd_arm_q;
   logic [`LBC_AW-1:0] snl_addr_q, upd_addr_q;
   logic [`LBC_FIFO_DEPTH == 8 ? 3 : 3:0] wq_level;

   assign snoop = ts & ~ag_q;
   assign pr = ts & ag_q;
   assign is_rd = req.tt[`LBC_TT_READ];
   assign is_dat = req.tt[`LBC_TT_DATA];
   assign snoop_rd = snoop & ((req.tt == `LBC_TT_CLEAN) | (is_dat & is_rd & (req.tt[1:4] == `LBC_TT_RD_LOW)));
   assign claim_rd = pr & is_dat & is_rd & tag_hit & ~req.inhibit;
   assign claim_wr = pr & is_dat & ~is_rd & tag_hit & ~req.inhibit & ~req.wthru;
   assign ci_clean = pr & is_dat & is_rd & tag_hit & req.inhibit & ~tag_dirty;
   assign ci_dirty = pr & is_dat & is_rd & tag_hit & req.inhibit & tag_dirty;
   assign wt_hit = pr & is_dat & ~is_rd & tag_hit & tag_dirty & ~req.burst
                 & (req.inhibit | req.wthru);
   assign sn_hit = snoop_rd & tag_hit & tag_dirty;
   assign retry_now = ci_dirty | wt_hit | sn_hit;
   assign room = (wq_level <= `LBC_FILL_MAX_LEVEL);
   assign fill = pr & is_dat & is_rd & ~tag_hit & req.burst & ~req.inhibit & room;
   assign upd = pr & is_dat & ~is_rd & upd_arm_q & room
              & (req.addr[`LBC_AW-1:`LBC_LINE_LSB] == upd_addr_q[`LBC_AW-1:`LBC_LINE_LSB]);
   assign enq = ts & is_dat;
   assign drop = win_q & artry_seen & tail_dat_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ag_q <= 1'b0;
         ap_q <= 1'b0;
         win_q <= 1'b0;
         brw_q <= 1'b0;
         tail_dat_q <= 1'b0;
         inv_q <= 1'b0;
         tenure_addr_q <= '0;
      end else if (clk_en) begin
         ag_q <= proc_addr_grant;
         ap_q <= ts | (ap_q & ~aack_seen);
         win_q <= ap_q & aack_seen;
         brw_q <= win_q & artry_seen;
         if (ts) begin
            tail_dat_q <= is_dat;
            inv_q <= ci_clean;
            tenure_addr_q <= req.addr;
         end
      end
   end

   // retry is held from the cycle after the start through the retry window
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         artry_q <= 1'b0;
      end else if (clk_en) begin
         artry_q <= retry_now | (artry_q & ~win_q);
      end
   end
   assign artry_drive = artry_q;
   assign artry_drive_en = artry_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tag_win_upd <= '0;
      end else if (clk_en) begin
         tag_win_upd.op <= (win_q & ~artry_seen & inv_q) ? TO_INVAL : TO_NONE;
         tag_win_upd.addr <= tenure_addr_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outstanding data tenures
   lbc_ten_t q_q [2];
   lbc_ten_t q_d [2];
   lbc_ten_t ten_new, front;
   logic [1:0] cnt_q, cnt_d, beat_q, last_beat, rd_beat;
   logic fin, ours, act, start, ten_q, gs_q, end_q, prv_rd_q, stream_ok;
   logic wq_push, wq_ready;
   logic [`LBC_AW-1:0] rd_line;

   assign front = q_q[0];
   assign ours = (front.kind == DK_HIT_RD) | (front.kind == DK_HIT_WR);
   assign last_beat = front.burst ? `LBC_LAST_BURST : `LBC_LAST_SINGLE;
   assign fin = (cnt_q != 2'h0) & ((ta_seen & (beat_q == last_beat)) | tea_seen);
   assign ten_new.kind = claim_rd ? DK_HIT_RD : claim_wr ? DK_HIT_WR : fill ? DK_FILL
                       : upd ? DK_UPD : DK_OTHER;
   assign ten_new.burst = req.burst;
   assign ten_new.addr = req.addr;

   always_comb begin
      q_d = q_q;
      cnt_d = cnt_q;
      if (fin) begin
         q_d[0] = q_q[1];
         cnt_d = cnt_q - 2'h1;
      end
      if (drop && cnt_d != 2'h0) begin
         cnt_d = cnt_d - 2'h1;
      end
      if (enq && cnt_d != 2'h2) begin
         q_d[cnt_d[0]] = ten_new;
         cnt_d = cnt_d + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q_q[0] <= '{kind: DK_OTHER, burst: 1'b0, addr: '0};
         q_q[1] <= '{kind: DK_OTHER, burst: 1'b0, addr: '0};
         cnt_q <= 2'h0;
         beat_q <= 2'h0;
      end else if (clk_en) begin
         q_q <= q_d;
         cnt_q <= cnt_d;
         if (fin || cnt_d == 2'h0) beat_q <= 2'h0;
         else if (ta_seen) beat_q <= beat_q + 2'h1;
      end
   end

   // data grant is taken as qualified, the busy line is not looked at
   assign stream_ok = retry_free_fast_mode & prv_rd_q & (front.kind == DK_HIT_RD);
   assign start = (cnt_q != 2'h0) & ~ten_q & gs_q & (~end_q | stream_ok);
   assign act = ten_q | start;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gs_q <= 1'b0;
         end_q <= 1'b0;
         prv_rd_q <= 1'b0;
         ten_q <= 1'b0;
      end else if (clk_en) begin
         gs_q <= proc_data_grant & (~ten_q | fin);
         end_q <= fin;
         prv_rd_q <= fin & ~tea_seen & (front.kind == DK_HIT_RD);
         ten_q <= act & ~fin & (cnt_d != 2'h0);
      end
   end

   // our reads ack every cycle; our writes stall only on a full write queue
   assign ta_drive = act & ((front.kind == DK_HIT_RD) | ((front.kind == DK_HIT_WR) & wq_ready));
   assign ta_drive_en = act & ours;
   assign data_drive_en = act & (front.kind == DK_HIT_RD);

   // array read address looks one beat ahead so the data leaves a flop
   always_comb begin
      rd_line = front.addr;
      rd_beat = ta_drive ? beat_q + 2'h1 : beat_q;
      if (fin) begin
         rd_line = (cnt_q == 2'h2) ? q_q[1].addr : req.addr;
         rd_beat = 2'h0;
      end else if (cnt_q == 2'h0) begin
         rd_line = req.addr;
         rd_beat = 2'h0;
      end
   end
   assign arr_rd_addr = beat_addr(rd_line, rd_beat);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_drive <= '0;
      end else if (clk_en) begin
         data_drive <= arr_rd_data;
      end
   end

   assign wq_push = (ta_drive & (front.kind == DK_HIT_WR))
                  | ((cnt_q != 2'h0) & ta_seen & ((front.kind == DK_FILL) | (front.kind == DK_UPD)));

   lbc_fifo #(.W($bits(lbc_wr_t)), .D(`LBC_FIFO_DEPTH)) u_wq (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .in_valid(wq_push),
      .in_ready(wq_ready),
      .in_data({beat_addr(front.addr, beat_q), bus_data}),
      .out_valid(arr_wr_valid),
      .out_ready(arr_wr_ready),
      .out_data(arr_wr),
      .level(wq_level)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tag_end_upd <= '0;
      end else if (clk_en) begin
         tag_end_upd.addr <= front.addr;
         tag_end_upd.op <= TO_NONE;
         if (fin && !tea_seen) begin
            case (front.kind)
               DK_HIT_WR: tag_end_upd.op <= TO_DIRTY;
               DK_FILL: tag_end_upd.op <= TO_FILL;
               DK_UPD: tag_end_upd.op <= TO_CLEAN;
               default: tag_end_upd.op <= TO_NONE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // claim and address acknowledge pacing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_q <= 1'b0;
      end else if (clk_en) begin
         aw_q <= claim_rd | claim_wr | (aw_q & ~aack_drive);
      end
   end

   assign aack_drive = aw_q & ((cnt_q == 2'h1)
                     | ((cnt_q == 2'h2) & ours & ta_drive & (beat_q == last_beat)));
   assign aack_drive_en = aack_drive;
   assign hit_claim_drive = aw_q;
   assign hit_claim_drive_en = aw_q;

   ////////////////////////////////////////////////////////////////////////////
   // write back after retry and update from the processor's copy
   lbc_wb_st_t wb_st_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_st_q <= WB_IDLE;
         wb_addr <= '0;
      end else if (clk_en) begin
         case (wb_st_q)
            WB_IDLE: begin
               if (retry_now) begin
                  wb_st_q <= WB_HOLD;
                  wb_addr <= req.addr;
               end
            end
            WB_HOLD: begin
               if (brw_q) wb_st_q <= proc_bus_request ? WB_IDLE : WB_RUN;
            end
            WB_RUN: begin
               if (wb_done) wb_st_q <= WB_IDLE;
            end
            default: wb_st_q <= WB_IDLE;
         endcase
      end
   end
   assign wb_bus_request = (wb_st_q == WB_RUN);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tag_wb_upd <= '0;
      end else if (clk_en) begin
         tag_wb_upd.op <= (wb_st_q == WB_RUN && wb_done) ? TO_CLEAN : TO_NONE;
         tag_wb_upd.addr <= wb_addr;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         snl_q <= 1'b0;
         snl_addr_q <= '0;
         upd_arm_q <= 1'b0;
         upd_addr_q <= '0;
      end else if (clk_en) begin
         if (ts) begin
            snl_q <= snoop_rd & tag_hit;
            snl_addr_q <= req.addr;
         end else if (brw_q) begin
            snl_q <= 1'b0;
         end
         if (brw_q && snl_q && proc_bus_request) begin
            upd_arm_q <= 1'b1;
            upd_addr_q <= snl_addr_q;
         end else if (upd && enq) begin
            upd_arm_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || !clk_en);

   a_ack_idle_hit: assert property ((claim_rd | claim_wr) && cnt_q == 2'h0 |=> aack_drive && hit_claim_drive) else $error("idle hit not acked next cycle");
   a_snoop_no_claim: assert property (ts && !ag_q |=> !hit_claim_drive || $past(aw_q)) else $error("snoop was claimed");
   a_fast_start: assert property (claim_rd && proc_data_grant && cnt_q == 2'h0 && !ten_q |=> ta_drive && data_drive_en) else $error("read hit data not one cycle after start");
   a_burst_run: assert property (start && front.kind == DK_HIT_RD && front.burst && !artry_seen && !tea_seen |-> ta_drive ##1 ta_drive ##1 ta_drive ##1 ta_drive) else $error("read burst acks not consecutive");
   a_turnaround: assert property (ta_drive_en && fin && !retry_free_fast_mode |=> !ta_drive_en) else $error("no turnaround between tenures");
   a_hold_ack: assert property (aw_q && cnt_q == 2'h2 && !ours |-> !aack_drive) else $error("pipelined hit acked too early");
   a_retry_held: assert property (retry_now |=> artry_drive [*1] ##0 (artry_drive || $past(win_q))) else $error("retry not driven");
   a_wb_defer: assert property (wb_st_q == WB_HOLD && brw_q && proc_bus_request |=> wb_st_q == WB_IDLE && !wb_bus_request) else $error("write back not deferred");
   a_wb_request: assert property (wb_st_q == WB_HOLD && brw_q && !proc_bus_request |=> wb_bus_request) else $error("write back not requested");
   a_fill_capture: assert property (cnt_q != 2'h0 && ta_seen && front.kind == DK_FILL |-> wq_push) else $error("linefill beat not captured");
   a_drop_retry: assert property (drop && !fin && !enq && cnt_q != 2'h0 |=> cnt_q == $past(cnt_q) - 2'h1) else $error("retried tenure not dropped");
endmodule : lbc_ctrl

// [dv/lbc_bus_model.sv]
// far-side model: memory controller, data array, castout engine, wired bus lines
`timescale 1ns/1ps
`include "lbc_regs.svh"
module lbc_bus_model
   import lbc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic stall,
   input wire logic ts,
   input wire lbc_req_t req,
   input wire logic hit_claim_drive,
   input wire logic aack_drive,
   input wire logic aack_drive_en,
   input wire logic artry_drive,
   input wire logic artry_drive_en,
   input wire logic ta_drive,
   input wire logic ta_drive_en,
   input wire logic wb_bus_request,
   input wire logic [`LBC_AW-1:0] arr_rd_addr,
   output logic aack_seen,
   output logic artry_seen,
   output logic ta_seen,
   output logic tea_seen,
   output logic [`LBC_DW-1:0] bus_data,
   output logic [`LBC_DW-1:0] arr_rd_data,
   output logic arr_wr_ready,
   output logic wb_done,
   output logic busy
);
   logic [2:0] ph_q;
   logic [1:0] beat_q;
   logic [1:0] wbc_q;
   logic [2:0] cyc_q;
   logic [`LBC_DW-1:0] bd_q;
   lbc_req_t r_q;
   logic [31:0] ba;
   ////////////////////////////////////////////////////////////////////////////////
   assign ba = {r_q.addr[31:5], r_q.addr[4:3] + beat_q, 3'h0};
   assign aack_seen = (aack_drive & aack_drive_en) | (ph_q == 3'h2);
   assign artry_seen = artry_drive & artry_drive_en;
   assign ta_seen = (ta_drive & ta_drive_en) | (ph_q == 3'h4);
   assign tea_seen = 1'b0;
   // a released bus shows the inverse of its last value
   assign bus_data = (ph_q == 3'h4) ? {ba, ~ba} : ~bd_q;
   assign arr_rd_data = {arr_rd_addr, ~arr_rd_addr};
   assign arr_wr_ready = !stall && cyc_q != 3'h0;
   assign wb_done = wbc_q == 2'h3;
   assign busy = ph_q != 3'h0;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bd_q <= '0;
         cyc_q <= '0;
         wbc_q <= '0;
      end else begin
         bd_q <= bus_data;
         cyc_q <= cyc_q + 3'h1;
         wbc_q <= (wb_bus_request && !wb_done) ? wbc_q + 2'h1 : 2'h0;
      end
   end
   // unclaimed transfers: aack, retry window, then memory beats
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_q <= '0;
         beat_q <= '0;
         r_q <= '0;
      end else begin
         case (ph_q)
            3'h0: if (ts) begin
               ph_q <= 3'h1;
               r_q <= req;
            end
            3'h1: ph_q <= hit_claim_drive ? 3'h0 : 3'h2;
            3'h2: ph_q <= 3'h3;
            3'h3: begin
               ph_q <= (artry_seen || !r_q.tt[3]) ? 3'h0 : 3'h4;
               beat_q <= 2'h0;
            end
            default: begin
               beat_q <= beat_q + 2'h1;
               if (beat_q == (r_q.burst ? 2'h3 : 2'h0)) ph_q <= 3'h0;
            end
         endcase
      end
   end
endmodule : lbc_bus_model

// [dv/lookaside_l2_bus_control_tb.sv]
// self-checking bench for the lookaside cache bus control
`timescale 1ns/1ps
`include "lbc_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module lookaside_l2_bus_control_tb
   import lbc_pkg::*;
;
   typedef struct packed {
      logic [31:0] a;
      logic [4:0] tt;
      logic [6:0] f;
      logic [4:0] e;
   } lbc_row_t;
   logic clk, reset_n, clk_en, retry_free_fast_mode, ts, stall;
   logic proc_addr_grant, proc_data_grant, proc_bus_request, tag_hit, tag_dirty;
   logic hit_claim_drive, hit_claim_drive_en, aack_drive, aack_drive_en;
   logic artry_drive, artry_drive_en, ta_drive, ta_drive_en, data_drive_en;
   logic aack_seen, artry_seen, ta_seen, tea_seen, arr_wr_valid, arr_wr_ready;
   logic wb_bus_request, wb_done, busy;
   logic [`LBC_DW-1:0] data_drive, bus_data, arr_rd_data;
   logic [`LBC_AW-1:0] arr_rd_addr, wb_addr;
   lbc_req_t req;
   lbc_wr_t arr_wr;
   lbc_tag_upd_t tag_win_upd, tag_end_upd, tag_wb_upd;
   lbc_row_t rows [12];
   int n_checks = 0;
   int n_mismatch = 0;
   int n_wr = 0;
   int n_fill = 0;
   ////////////////////////////////////////////////////////////////////////////////
   lbc_ctrl u_lbc_ctrl (.clk, .reset_n, .clk_en, .retry_free_fast_mode, .ts, .req,
      .proc_addr_grant, .proc_data_grant, .proc_bus_request, .aack_seen, .artry_seen,
      .ta_seen, .tea_seen, .bus_data, .tag_hit, .tag_dirty, .hit_claim_drive,
      .hit_claim_drive_en, .aack_drive, .aack_drive_en, .artry_drive, .artry_drive_en,
      .ta_drive, .ta_drive_en, .data_drive, .data_drive_en, .arr_rd_addr, .arr_rd_data,
      .arr_wr_valid, .arr_wr_ready, .arr_wr, .tag_win_upd, .tag_end_upd, .tag_wb_upd,
      .wb_bus_request, .wb_addr, .wb_done);
   lbc_bus_model u_lbc_bus_model (.clk, .reset_n, .stall, .ts, .req, .hit_claim_drive,
      .aack_drive, .aack_drive_en, .artry_drive, .artry_drive_en, .ta_drive, .ta_drive_en,
      .wb_bus_request, .arr_rd_addr, .aack_seen, .artry_seen, .ta_seen, .tea_seen,
      .bus_data, .arr_rd_data, .arr_wr_ready, .wb_done, .busy);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // bus beats from memory carry their own address, so captured lines can be recognised
   always @(posedge clk) if (arr_wr_valid === 1'b1 && arr_wr_ready) begin
      n_wr++;
      if (arr_wr.data === {arr_wr.addr, ~arr_wr.addr}) n_fill++;
   end
   task automatic summarize;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask : summarize
   // f = {burst, inhibit, wthru, hit, dirty, addr grant, bus request}
   task automatic issue(input lbc_row_t r);
      begin
         @(posedge clk);
         proc_addr_grant <= r.f[1];
         proc_bus_request <= r.f[0];
         @(posedge clk);
         ts <= 1'b1;
         req <= '{addr: r.a, tt: r.tt, burst: r.f[6], inhibit: r.f[5], wthru: r.f[4]};
         tag_hit <= r.f[3];
         tag_dirty <= r.f[2];
         @(posedge clk);
         ts <= 1'b0;
         tag_hit <= 1'b0;
         tag_dirty <= 1'b0;
      end
   endtask : issue
   // e = {claim, retry, write back, fill or update, invalidate}
   task automatic run_row(input lbc_row_t r);
      int n;
      logic sw, sf, si;
      logic [31:0] ba;
      begin
         issue(r);
         @(negedge clk);
         `CHK(hit_claim_drive, r.e[4])
         `CHK(artry_drive & artry_drive_en, r.e[3])
         if (r.e[4]) begin
            `CHK(aack_drive & aack_drive_en, 1'b1)
            for (n = 0; n < 5; n++) begin
               ba = {r.a[31:5], r.a[4:3] + n[1:0], 3'h0};
               `CHK(ta_drive & ta_drive_en, n < (r.f[6] ? 4 : 1))
               `CHK(data_drive_en, n < (r.f[6] ? 4 : 1) && req.tt[1])
               if (n < (r.f[6] ? 4 : 1) && req.tt[1]) `CHK(data_drive, {ba, ~ba})
               @(negedge clk);
            end
         end
         sw = 1'b0;
         sf = 1'b0;
         si = 1'b0;
         for (n = 0; n < 40 && (busy || wb_bus_request || artry_drive || n < 10); n++) begin
            sw |= wb_bus_request === 1'b1;
            if (wb_bus_request === 1'b1) `CHK(wb_addr, r.a)
            sf |= tag_end_upd.op === TO_FILL || tag_end_upd.op === TO_CLEAN;
            si |= tag_win_upd.op === TO_INVAL;
            @(negedge clk);
         end
         `CHK(sw, r.e[2])
         `CHK(sf, r.e[1])
         `CHK(si, r.e[0])
         `CHK(n < 40, 1'b1)
      end
   endtask : run_row
   // two read hits, second pipelined behind the first
   task automatic stream(input logic fast, input logic [8:0] exp_ta);
      logic [8:0] tv, av;
      int i;
      begin
         @(posedge clk);
         retry_free_fast_mode <= fast;
         issue('{32'hc000, 5'h0a, 7'b1001010, 5'h0});
         for (i = 0; i < 9; i++) begin
            @(negedge clk);
            tv[i] = ta_drive & ta_drive_en;
            av[i] = aack_drive & aack_drive_en;
            @(posedge clk);
            ts <= i == 1;
            tag_hit <= i == 1;
            if (i == 1) req.addr <= 32'hc020;
         end
         `CHK(tv, exp_ta)
         `CHK(av, 9'h009)
      end
   endtask : stream
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      n_mismatch++;
      summarize();
   end
   initial begin
      int n, wr0;
      logic [7:0] k;
      reset_n = 1'b0;
      clk_en = 1'b1;
      retry_free_fast_mode = 1'b0;
      ts = 1'b0;
      stall = 1'b0;
      req = '0;
      proc_addr_grant = 1'b1;
      proc_data_grant = 1'b1;
      proc_bus_request = 1'b0;
      tag_hit = 1'b0;
      tag_dirty = 1'b0;
      rows = '{'{32'h1008, 5'h0a, 7'b1001010, 5'b10000},
               '{32'h2000, 5'h0a, 7'b1101010, 5'b00001},
               '{32'h3000, 5'h0a, 7'b1101110, 5'b01100},
               '{32'h4010, 5'h0a, 7'b1000010, 5'b00010},
               '{32'h5000, 5'h02, 7'b1001010, 5'b10000},
               '{32'h6000, 5'h02, 7'b0011110, 5'b01100},
               '{32'h7000, 5'h0a, 7'b1001000, 5'b00000},
               '{32'h8000, 5'h00, 7'b1001100, 5'b01100},
               '{32'h9000, 5'h0a, 7'b1001101, 5'b01000},
               '{32'h9000, 5'h02, 7'b1000010, 5'b00010},
               '{32'ha018, 5'h0a, 7'b0001010, 5'b10000},
               '{32'hb000, 5'h0a, 7'b1100010, 5'b00000}};
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      `CHK(n_fill, 8)
      stream(1'b1, 9'h0ff);
      stream(1'b0, 9'h1ef);
      // stalled array: fifo fills, third write's first beat is acked and its other acknowledges wait
      wr0 = n_wr;
      @(posedge clk);
      stall <= 1'b1;
      run_row(rows[4]);
      run_row(rows[4]);
      issue(rows[4]);
      k = 8'h0;
      for (n = 0; n < 8; n++) begin
         @(negedge clk);
         k += ta_drive & ta_drive_en;
      end
      `CHK(k, 8'h1)
      @(posedge clk);
      stall <= 1'b0;
      for (n = 0; n < 30; n++) begin
         @(negedge clk);
         k += ta_drive & ta_drive_en;
      end
      `CHK(k, 8'h4)
      `CHK(n_wr, wr0 + 12)
      // second reset in mid-run
      @(posedge clk);
      reset_n <= 1'b0;
      @(negedge clk);
      `CHK({hit_claim_drive, aack_drive, artry_drive, ta_drive_en, wb_bus_request}, 5'h0)
      `CHK(tag_end_upd.op, TO_NONE)
      @(posedge clk);
      reset_n <= 1'b1;
      run_row(rows[0]);
      summarize();
   end
endmodule : lookaside_l2_bus_control_tb
